//--- rtl/tsi_pkg.sv
// What this block does
// - on access end, acknowledge drives high one cycle, then releases
// - frame evaluation input timed against the incoming frame pulse
// - frame pulse polarity (GCI or alternative) learned from its idle level
// - master enable and standby both low: every serial output floats
// - master enable high turns serial drivers on, per-channel control still applies
// - a channel whose connection entry selects high impedance floats
// - reset clears counters and registers except the format flag (set to GCI) and the acknowledge (set high), floats serial lanes and data bus
// - read/write select picks data bus drive (read) or sample (write)
// - input lanes carry 512 eight-bit channels per frame
// - output lanes run at exactly the input lane bit rate
// - test data out changes on test clock fall, floats outside scans
// - test reset forces the test port to Test-Logic-Reset asynchronously
// - upper pins carry lanes 16-31, or drive status of lanes 0-15
// - any input channel switches to any output channel without blocking
// - each output channel takes switched data or host-written processor data
// - each input lane may lag the frame by up to 7.5 bits in half bits
// - one serial bit per master bit clock period on every lane
package tsi_pkg;
  localparam int LANES         = 32;
  localparam int CHANS         = 512;
  localparam int CH_W          = 9;
  localparam int LANE_W        = 5;
  localparam int HIST_W        = 32;
  localparam int OFS_W         = 4;
  localparam int EVAL_W        = 13;
  localparam int CLK_NS        = 5;
  localparam int RESET_MIN_NS  = 20;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] IDLE_LOCK = 3'h7;
  localparam int HALF_BIT_LAG  = 16;
  // connection memory entry layout
  localparam int CM_MODE_HI    = 15;
  localparam int CM_MODE_LO    = 14;
  localparam int CM_LANE_HI    = 13;
  localparam int CM_LANE_LO    = 9;
  localparam int CM_CHAN_HI    = 8;
  localparam int CM_CHAN_LO    = 0;
  localparam logic [1:0] MODE_VAR   = 2'h0;
  localparam logic [1:0] MODE_CONST = 2'h1;
  localparam logic [1:0] MODE_PROC  = 2'h2;
  localparam logic [1:0] MODE_HIZ   = 2'h3;
  // host address: this bit selects data memory (read only)
  localparam int ADDR_DMEM_BIT = 14;

  typedef struct packed {
    logic        cs_n;
    logic        strobe_n;
    logic        rw;
    logic [15:0] addr;
    logic [15:0] wdata;
  } tsi_host_req_t;

  typedef struct packed {
    logic [15:0] data;
    logic        data_oe;
    logic        transfer_ack_n;
    logic        ack_oe;
  } tsi_host_pins_t;

  localparam tsi_host_pins_t HOST_PINS_RST = '{16'h0000, 1'b0, 1'b1, 1'b0};
endpackage : tsi_pkg

//--- rtl/tsi_host_port.sv
`timescale 1ns/1ps
`default_nettype none
module tsi_host_port
  import tsi_pkg::*;
(
  // clock and reset
  input  wire logic           i_clk,
  input  wire logic           i_rst,
  // host pins
  input  wire tsi_host_req_t  i_host,
  output var  tsi_host_pins_t o_host,
  // access handshake with the core
  output var  logic           o_req,
  input  wire logic           i_done,
  input  wire logic [15:0]    i_rdata
);
  typedef enum logic [1:0] {HP_IDLE, HP_WAIT, HP_ACK, HP_REL} tsi_hp_state_t;
  typedef struct packed {
    tsi_hp_state_t  st;
    logic           req;
    tsi_host_pins_t pins;
  } tsi_hp_st_t;

  tsi_hp_st_t s_reg;
  tsi_hp_st_t s_next;

  always_comb begin
    s_next = s_reg;
    unique case (s_reg.st)
      HP_IDLE: begin
        if (!i_host.cs_n && !i_host.strobe_n) begin
          s_next.st  = HP_WAIT;
          s_next.req = 1'b1;
        end
      end
      HP_WAIT: begin
        if (i_done) begin
          s_next.st                  = HP_ACK;
          s_next.req                 = 1'b0;
          s_next.pins.transfer_ack_n = 1'b0;
          s_next.pins.ack_oe         = 1'b1;
          s_next.pins.data           = i_rdata;
          s_next.pins.data_oe        = i_host.rw;
        end
      end
      HP_ACK: begin
        if (i_host.cs_n || i_host.strobe_n) begin
          s_next.st                  = HP_REL;
          s_next.pins.transfer_ack_n = 1'b1;
          s_next.pins.data_oe        = 1'b0;
        end
      end
      HP_REL: begin
        s_next.st          = HP_IDLE;
        s_next.pins.ack_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_reg <= '{HP_IDLE, 1'b0, HOST_PINS_RST};
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_host = s_reg.pins;
  assign o_req  = s_reg.req;

  default clocking hp_cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_ack_after_done;
    $fell(o_host.transfer_ack_n) |-> $past(i_done) && $past(o_req);
  endproperty
  a_ack_after_done: assert property (p_ack_after_done)
    else $error("acknowledge fell without a completed access");

  property p_ack_release;
    $rose(o_host.transfer_ack_n) |-> o_host.ack_oe ##1 !o_host.ack_oe;
  endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("acknowledge not driven high then released");

  property p_read_drive;
    o_host.data_oe |-> !o_host.transfer_ack_n && o_host.ack_oe;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("data bus driven outside an acknowledged read");

  c_full_access: cover property (
    $fell(o_host.transfer_ack_n) ##[1:20] $rose(o_host.transfer_ack_n));
endmodule : tsi_host_port
`default_nettype wire

//--- rtl/tsi_core.sv
`timescale 1ns/1ps
`default_nettype none
module tsi_core
  import tsi_pkg::*;
(
  // clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  // serial side
  input  wire logic                        i_bit_clock_in,
  input  wire logic                        i_frame_pulse_in,
  input  wire logic                        i_frame_eval_in,
  input  wire logic [LANES-1:0]            i_serial_in_lanes,
  output var  logic [15:0]                 o_serial_out_lanes_low,
  output var  logic [15:0]                 o_serial_out_lanes_low_oe,
  output var  logic [15:0]                 o_upper_out_or_drive_status,
  output var  logic [15:0]                 o_upper_out_oe,
  // drive and lane control
  input  wire logic                        i_tx_master_drive_en,
  input  wire logic                        i_standby_drive_bit,
  input  wire logic                        i_all_lanes_sel,
  input  wire logic [LANES-1:0][OFS_W-1:0] i_lane_offset,
  // frame evaluation
  input  wire logic                        i_eval_start,
  output var  logic                        o_eval_done,
  output var  logic [EVAL_W-1:0]           o_eval_count,
  output var  logic                        o_format_gci,
  // host port
  input  wire tsi_host_req_t               i_host,
  output var  tsi_host_pins_t              o_host,
  // test access port
  input  wire logic                        i_test_clock,
  input  wire logic                        i_test_mode_sel,
  input  wire logic                        i_test_data_in,
  input  wire logic                        i_test_reset_n,
  output var  logic                        o_test_data_out,
  output var  logic                        o_test_data_out_oe
);
  typedef enum logic [1:0] {EV_IDLE, EV_ARM, EV_COUNT, EV_DONE} tsi_ev_t;
  typedef enum logic [3:0] {
    TP_TLR, TP_RTI, TP_SEL_DR, TP_CAP_DR, TP_SH_DR, TP_EX1_DR, TP_PA_DR,
    TP_EX2_DR, TP_UPD_DR, TP_SEL_IR, TP_CAP_IR, TP_SH_IR, TP_EX1_IR,
    TP_PA_IR, TP_EX2_IR, TP_UPD_IR
  } tsi_tap_t;

  typedef struct packed {
    logic                        clk_q;
    logic                        fp_q;
    logic                        fe_q;
    logic [2:0]                  idle_cnt;
    logic                        idle_lvl;
    logic                        fmt_gci;
    logic                        locked;
    logic [2:0]                  bit_cnt;
    logic [CH_W-1:0]             chan;
    logic [LANES-1:0][HIST_W-1:0] hist;
    logic [LANES-1:0][7:0]       cur_byte;
    logic [LANES-1:0][7:0]       next_byte;
    logic [LANES-1:0]            next_drv;
    logic [LANES-1:0]            lane_oe;
    logic [LANES-1:0]            lane_bit;
    logic [15:0]                 up_val;
    logic [15:0]                 up_oe;
    logic                        seq_run;
    logic [LANE_W-1:0]           seq_k;
    logic [CH_W-1:0]             seq_chan;
    tsi_ev_t                     ev;
    logic                        start_q;
    logic [EVAL_W-1:0]           eval_cnt;
    logic                        eval_done;
    logic                        host_done;
    logic [15:0]                 host_rdata;
  } tsi_core_st_t;

  typedef struct packed {
    tsi_tap_t st;
    logic     tck_q;
    logic     byp;
    logic     tdo;
    logic     tdo_oe;
  } tsi_tap_st_t;

  // lagged byte: last bit sits HALF_BIT_LAG - d half samples back
  function automatic logic [7:0] pick_byte(input logic [HIST_W-1:0] h,
                                           input logic [OFS_W-1:0]  d);
    logic [7:0] b;
    int         idx;
    b = 8'h00;
    for (int j = 0; j < 8; j++) begin
      idx  = HALF_BIT_LAG - int'(d) + 2 * j;
      b[j] = h[idx[4:0]];
    end
    return b;
  endfunction : pick_byte

  function automatic tsi_tap_t tap_step(input tsi_tap_t st, input logic tms);
    unique case (st)
      TP_TLR:    tap_step = tms ? TP_TLR    : TP_RTI;
      TP_RTI:    tap_step = tms ? TP_SEL_DR : TP_RTI;
      TP_SEL_DR: tap_step = tms ? TP_SEL_IR : TP_CAP_DR;
      TP_CAP_DR: tap_step = tms ? TP_EX1_DR : TP_SH_DR;
      TP_SH_DR:  tap_step = tms ? TP_EX1_DR : TP_SH_DR;
      TP_EX1_DR: tap_step = tms ? TP_UPD_DR : TP_PA_DR;
      TP_PA_DR:  tap_step = tms ? TP_EX2_DR : TP_PA_DR;
      TP_EX2_DR: tap_step = tms ? TP_UPD_DR : TP_SH_DR;
      TP_UPD_DR: tap_step = tms ? TP_SEL_DR : TP_RTI;
      TP_SEL_IR: tap_step = tms ? TP_TLR    : TP_CAP_IR;
      TP_CAP_IR: tap_step = tms ? TP_EX1_IR : TP_SH_IR;
      TP_SH_IR:  tap_step = tms ? TP_EX1_IR : TP_SH_IR;
      TP_EX1_IR: tap_step = tms ? TP_UPD_IR : TP_PA_IR;
      TP_PA_IR:  tap_step = tms ? TP_EX2_IR : TP_PA_IR;
      TP_EX2_IR: tap_step = tms ? TP_UPD_IR : TP_SH_IR;
      TP_UPD_IR: tap_step = tms ? TP_SEL_DR : TP_RTI;
    endcase
  endfunction : tap_step

  tsi_core_st_t          s_reg;
  tsi_core_st_t          s_next;
  tsi_tap_st_t           t_reg;
  tsi_tap_st_t           t_next;
  // whole frame of every lane, one word per channel, plus switch map;
  // both start at zero so unprogrammed entries never carry unknowns
  logic [LANES-1:0][7:0] dmem [CHANS] = '{default: '0};
  logic [15:0]           cmem [LANES*CHANS] = '{default: '0};

  logic                  rise;
  logic                  fall;
  logic                  bnd;
  logic                  fstart;
  logic                  eval_edge;
  logic                  drive_ok;
  logic                  serve;
  logic                  host_req;
  logic [15:0]           cm_ent;
  logic [LANES-1:0][7:0] src_word;
  logic [LANES-1:0][7:0] cap_word;
  logic [LANES-1:0][7:0] host_word;
  logic [15:0]           host_rd;
  logic                  tck_rise;
  logic                  tck_fall;
  logic                  tap_shift;

  assign rise      = i_bit_clock_in & ~s_reg.clk_q;
  assign fall      = ~i_bit_clock_in & s_reg.clk_q;
  assign bnd       = rise & s_reg.locked & (s_reg.bit_cnt == 3'h7);
  assign fstart    = rise & s_reg.locked & (s_reg.fp_q == s_reg.idle_lvl)
                     & (i_frame_pulse_in != s_reg.idle_lvl);
  assign eval_edge = (rise | fall) & (s_reg.fe_q == s_reg.idle_lvl)
                     & (i_frame_eval_in != s_reg.idle_lvl);
  assign drive_ok  = i_tx_master_drive_en | i_standby_drive_bit;
  // host waits while the sequencer owns the memories
  assign serve     = host_req & ~s_reg.seq_run & ~bnd & ~s_reg.host_done;

  assign cm_ent    = cmem[{s_reg.seq_k, s_reg.seq_chan}];
  assign src_word  = dmem[cm_ent[CM_CHAN_HI:CM_CHAN_LO]];
  assign host_word = dmem[i_host.addr[CM_CHAN_HI:CM_CHAN_LO]];
  assign host_rd   = i_host.addr[ADDR_DMEM_BIT]
                     ? {8'h00, host_word[i_host.addr[CM_LANE_HI:CM_LANE_LO]]}
                     : cmem[i_host.addr[CM_LANE_HI:0]];

  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      cap_word[l] = pick_byte(s_reg.hist[l], i_lane_offset[l]);
    end
  end

  always_comb begin
    s_next           = s_reg;
    s_next.clk_q     = i_bit_clock_in;
    s_next.host_done = serve;
    s_next.start_q   = i_eval_start;
    if (serve) begin
      s_next.host_rdata = host_rd;
    end
    if (rise | fall) begin
      s_next.fe_q = i_frame_eval_in;
      for (int l = 0; l < LANES; l++) begin
        s_next.hist[l] = {s_reg.hist[l][HIST_W-2:0], i_serial_in_lanes[l]};
      end
    end
    // sequencer fetches one output lane per cycle for the coming channel
    if (s_reg.seq_run) begin
      s_next.next_byte[s_reg.seq_k] =
        (cm_ent[CM_MODE_HI:CM_MODE_LO] == MODE_PROC) ? cm_ent[7:0]
        : src_word[cm_ent[CM_LANE_HI:CM_LANE_LO]];
      s_next.next_drv[s_reg.seq_k] =
        (cm_ent[CM_MODE_HI:CM_MODE_LO] != MODE_HIZ);
      s_next.seq_k = s_reg.seq_k + 5'h01;
      if (s_reg.seq_k == 5'h1F) begin
        s_next.seq_run = 1'b0;
      end
    end
    if (rise) begin
      s_next.fp_q = i_frame_pulse_in;
      // a level held for a run of bits is the idle level of the pulse
      if (i_frame_pulse_in != s_reg.fp_q) begin
        s_next.idle_cnt = 3'h0;
      end else if (s_reg.idle_cnt != IDLE_LOCK) begin
        s_next.idle_cnt = s_reg.idle_cnt + 3'h1;
      end else begin
        s_next.locked   = 1'b1;
        s_next.idle_lvl = i_frame_pulse_in;
        s_next.fmt_gci  = ~i_frame_pulse_in;
      end
      s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
      if (s_reg.bit_cnt == 3'h7) begin
        s_next.chan = s_reg.chan + 9'h001;
      end
      if (fstart) begin
        s_next.bit_cnt = 3'h0;
        s_next.chan    = '0;
      end
      if (bnd) begin
        s_next.lane_oe  = s_reg.next_drv & {LANES{drive_ok}};
        s_next.seq_run  = 1'b1;
        s_next.seq_k    = '0;
        s_next.seq_chan = s_next.chan + 9'h001;
      end
      for (int l = 0; l < LANES; l++) begin
        s_next.cur_byte[l] = bnd ? s_reg.next_byte[l] : s_reg.cur_byte[l];
        s_next.lane_bit[l] = s_next.cur_byte[l][3'h7 - s_next.bit_cnt];
      end
      if (i_all_lanes_sel) begin
        s_next.up_val = s_next.lane_bit[31:16];
        s_next.up_oe  = s_next.lane_oe[31:16];
      end else begin
        s_next.up_val = s_next.lane_oe[15:0];
        s_next.up_oe  = 16'hFFFF;
      end
    end
    // evaluation: arm on start rising, count half bits from frame start
    if (!i_eval_start) begin
      s_next.ev        = EV_IDLE;
      s_next.eval_done = 1'b0;
    end else begin
      unique case (s_reg.ev)
        EV_IDLE: begin
          if (!s_reg.start_q) begin
            s_next.ev = EV_ARM;
          end
        end
        EV_ARM: begin
          if (fstart) begin
            s_next.ev       = EV_COUNT;
            s_next.eval_cnt = '0;
          end
        end
        EV_COUNT: begin
          // the closing edge counts too: the result spans frame to edge
          if (rise | fall) begin
            s_next.eval_cnt = s_reg.eval_cnt + 13'h0001;
          end
          if (eval_edge || fstart) begin
            s_next.ev        = EV_DONE;
            s_next.eval_done = 1'b1;
          end
        end
        EV_DONE: begin
          s_next.ev = EV_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_reg    <= '0;
      s_reg.ev <= EV_IDLE;
      s_reg.fmt_gci <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (bnd) begin
      dmem[s_reg.chan - 9'h001] <= cap_word;
    end
    if (serve && !i_host.rw && !i_host.addr[ADDR_DMEM_BIT]) begin
      cmem[i_host.addr[CM_LANE_HI:0]] <= i_host.wdata;
    end
  end

  // test port: bypass path only, test clock sampled as a plain input
  assign tck_rise  = i_test_clock & ~t_reg.tck_q;
  assign tck_fall  = ~i_test_clock & t_reg.tck_q;
  assign tap_shift = (t_reg.st == TP_SH_DR) || (t_reg.st == TP_SH_IR);

  always_comb begin
    t_next       = t_reg;
    t_next.tck_q = i_test_clock;
    if (tck_rise) begin
      t_next.st = tap_step(t_reg.st, i_test_mode_sel);
      if (tap_shift) begin
        t_next.byp = i_test_data_in;
      end
    end
    if (tck_fall) begin
      t_next.tdo    = t_reg.byp;
      t_next.tdo_oe = tap_shift;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst or negedge i_test_reset_n) begin
    if (i_rst || !i_test_reset_n) begin
      t_reg    <= '0;
      t_reg.st <= TP_TLR;
    end else begin
      t_reg <= t_next;
    end
  end

  tsi_host_port u_host (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_host  (i_host),
    .o_host  (o_host),
    .o_req   (host_req),
    .i_done  (s_reg.host_done),
    .i_rdata (s_reg.host_rdata)
  );

  assign o_serial_out_lanes_low      = s_reg.lane_bit[15:0];
  assign o_serial_out_lanes_low_oe   = s_reg.lane_oe[15:0];
  assign o_upper_out_or_drive_status = s_reg.up_val;
  assign o_upper_out_oe              = s_reg.up_oe;
  assign o_eval_done                 = s_reg.eval_done;
  assign o_eval_count                = s_reg.eval_cnt;
  assign o_format_gci                = s_reg.fmt_gci;
  assign o_test_data_out             = t_reg.tdo;
  assign o_test_data_out_oe          = t_reg.tdo_oe;

  default clocking core_cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_all_float;
    bnd && !i_tx_master_drive_en && !i_standby_drive_bit
      |=> (o_serial_out_lanes_low_oe == 16'h0000);
  endproperty
  a_all_float: assert property (p_all_float)
    else $error("lanes driven with master enable and standby low");

  property p_drive_on;
    bnd && i_tx_master_drive_en && s_reg.next_drv[0]
      |=> o_serial_out_lanes_low_oe[0];
  endproperty
  a_drive_on: assert property (p_drive_on)
    else $error("lane 0 not driven with master enable high");

  property p_chan_float;
    bnd && !s_reg.next_drv[3] |=> !o_serial_out_lanes_low_oe[3];
  endproperty
  a_chan_float: assert property (p_chan_float)
    else $error("channel selected high impedance yet driven");

  property p_oe_on_boundary;
    !bnd |=> $stable(s_reg.lane_oe);
  endproperty
  a_oe_on_boundary: assert property (p_oe_on_boundary)
    else $error("drive enable changed inside a channel");

  property p_one_bit_per_clock;
    !rise |=> $stable(o_serial_out_lanes_low);
  endproperty
  a_one_bit_per_clock: assert property (p_one_bit_per_clock)
    else $error("output lane changed without a bit clock edge");

  property p_status_pins;
    rise && !i_all_lanes_sel
      |=> o_upper_out_or_drive_status == s_reg.lane_oe[15:0]
          && o_upper_out_oe == 16'hFFFF;
  endproperty
  a_status_pins: assert property (p_status_pins)
    else $error("status pins do not show lane drive state");

  property p_format_lock;
    rise && (i_frame_pulse_in == s_reg.fp_q) && (s_reg.idle_cnt == IDLE_LOCK)
      |=> s_reg.locked && (s_reg.idle_lvl == $past(i_frame_pulse_in));
  endproperty
  a_format_lock: assert property (p_format_lock)
    else $error("frame pulse idle level not learned");

  property p_eval_done;
    $rose(o_eval_done) |-> $past(s_reg.ev == EV_COUNT)
      && $past(eval_edge || fstart);
  endproperty
  a_eval_done: assert property (p_eval_done)
    else $error("evaluation done without an edge or frame end");

  property p_tdo_float;
    tck_fall && !tap_shift |=> !o_test_data_out_oe;
  endproperty
  a_tdo_float: assert property (p_tdo_float)
    else $error("test data out driven outside a scan");

  property p_reset_float;
    @(posedge i_clk) disable iff (1'b0)
      i_rst |=> (o_serial_out_lanes_low_oe == 16'h0000)
        && (o_upper_out_oe == 16'h0000) && !o_host.data_oe;
  endproperty
  a_reset_float: assert property (p_reset_float)
    else $error("outputs driven during reset");

  c_frame_start: cover property (fstart ##[1:300] bnd);
  c_eval: cover property ($rose(o_eval_done));
  c_proc_chan: cover property (s_reg.seq_run
                               && cm_ent[CM_MODE_HI:CM_MODE_LO] == MODE_PROC);
endmodule : tsi_core
`default_nettype wire

//--- verif/tsi_backplane.sv
`timescale 1ns/1ps
`default_nettype none
module tsi_backplane
  import tsi_pkg::*;
(
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // backplane lines
  output wire logic             o_bit_clock,
  output wire logic             o_frame_pulse,
  output wire logic             o_frame_eval,
  output wire logic [LANES-1:0] o_lanes
);
  logic [2:0]  phase_reg;
  logic [11:0] bit_reg;
  // six system cycles a bit is the nearest whole ratio to the line rate;
  // the fetch sequencer needs 32 of the 48 cycles of a channel, so a
  // faster bit clock would starve the host port
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_reg <= 3'h0;
      bit_reg   <= 12'h000;
    end else if (phase_reg == 3'h5) begin
      phase_reg <= 3'h0;
      bit_reg   <= bit_reg + 12'h001;
    end else begin
      phase_reg <= phase_reg + 3'h1;
    end
  end
  assign o_bit_clock   = (phase_reg >= 3'h3);
  // active-high pulse on bit 0 of 4096 bits, so the idle level is low
  assign o_frame_pulse = (bit_reg == 12'h000);
  assign o_frame_eval  = (bit_reg >= 12'h010);
  assign o_lanes       = {LANES{bit_reg[0] ^ bit_reg[3]}};
endmodule : tsi_backplane
`default_nettype wire

//--- verif/tsi_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module tsi_core_test;
  import tsi_pkg::*;
  logic                        i_clk, i_rst, bclk, fp, fe;
  logic                        mdrv, stby, evs, trst_n, ev_done, gci;
  logic                        tdo, tdo_oe, tck, tms;
  logic [EVAL_W-1:0]           ev_cnt;
  logic [LANES-1:0]            rx;
  logic [15:0]                 lo, lo_oe, up, up_oe, rd;
  logic [LANES-1:0][OFS_W-1:0] ofs;
  tsi_host_req_t               host;
  tsi_host_pins_t              pins;
  int                          failures, comparisons, cyc, on, ones, st;

  tsi_backplane far_end (.i_clk(i_clk), .i_rst(i_rst), .o_bit_clock(bclk),
    .o_frame_pulse(fp), .o_frame_eval(fe), .o_lanes(rx));

  tsi_core dut (.i_clk(i_clk), .i_rst(i_rst), .i_bit_clock_in(bclk),
    .i_frame_pulse_in(fp), .i_frame_eval_in(fe), .i_serial_in_lanes(rx),
    .o_serial_out_lanes_low(lo), .o_serial_out_lanes_low_oe(lo_oe),
    .o_upper_out_or_drive_status(up), .o_upper_out_oe(up_oe),
    .i_tx_master_drive_en(mdrv), .i_standby_drive_bit(stby),
    .i_all_lanes_sel(1'b0), .i_lane_offset(ofs), .i_eval_start(evs),
    .o_eval_done(ev_done), .o_eval_count(ev_cnt), .o_format_gci(gci),
    .i_host(host), .o_host(pins), .i_test_clock(tck),
    .i_test_mode_sel(tms), .i_test_data_in(1'b1),
    .i_test_reset_n(trst_n), .o_test_data_out(tdo),
    .o_test_data_out_oe(tdo_oe));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic check(input string what, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  // one access: request held until the acknowledge is seen low
  task automatic acc(input logic rw, input logic [15:0] a, wd);
    int n;
    n = 0;
    host = '{1'b0, 1'b0, rw, a, wd};
    while (pins.transfer_ack_n !== 1'b0 && n < 200) begin
      @(negedge i_clk);
      n++;
    end
    check("ack wait", 16'(n >= 3 && n < 200), 16'h0001);
    check("bus dir", {15'h0000, pins.data_oe}, {15'h0000, rw});
    rd = pins.data;
    host.strobe_n = 1'b1;
    host.cs_n = 1'b1;
    @(negedge i_clk);
    check("ack high", {pins.ack_oe, pins.transfer_ack_n}, 16'h0003);
    @(negedge i_clk);
    check("ack free", {15'h0000, pins.ack_oe}, 16'h0000);
  endtask : acc

  // one test clock period, each half spanning two system cycles
  task automatic tap_clk(input logic mode);
    tms = mode;
    tck = 1'b1;
    repeat (2) @(negedge i_clk);
    tck = 1'b0;
    repeat (2) @(negedge i_clk);
  endtask : tap_clk

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 99000) begin
      failures++;
      stop_test();
    end
  end

  initial begin
    i_rst = 1'b1;
    trst_n = 1'b0;
    mdrv = 1'b0;
    stby = 1'b0;
    evs = 1'b0;
    ofs = '0;
    tck = 1'b0;
    tms = 1'b1;
    host = '{1'b1, 1'b1, 1'b1, 16'h0000, 16'h0000};
    failures = 0;
    comparisons = 0;
    cyc = 0;
    repeat (4) @(negedge i_clk);
    check("reset oe", lo_oe | up_oe, 16'h0000);
    check("reset bus", {pins.ack_oe, pins.data_oe}, 16'h0000);
    i_rst = 1'b0;
    trst_n = 1'b1;
    // lane 0: even channels carry a host byte, odd channels float
    for (int c = 0; c < CHANS; c++) begin
      acc(1'b0, 16'(c), (c % 2) ? 16'hC000 : 16'h80A5);
    end
    acc(1'b1, 16'h0001, 16'h0000);
    check("entry", rd, 16'hC000);
    check("test out oe", {15'h0000, tdo_oe}, 16'h0000);
    check("format", {15'h0000, gci}, 16'h0001);
    $display("test host access done");
    // walk the test port into shift-DR; the bypass bit follows TDI out
    tap_clk(1'b0);
    tap_clk(1'b1);
    tap_clk(1'b0);
    tap_clk(1'b0);
    check("scan oe", {15'h0000, tdo_oe}, 16'h0001);
    tap_clk(1'b0);
    check("scan out", {15'h0000, tdo}, 16'h0001);
    trst_n = 1'b0;
    @(negedge i_clk);
    check("test reset", {15'h0000, tdo_oe}, 16'h0000);
    trst_n = 1'b1;
    $display("test port done");
    evs = 1'b1;
    for (int m = 0; m < 3; m++) begin
      {mdrv, stby} = m[1:0];
      repeat (64) @(negedge i_clk);
      on = 0;
      ones = 0;
      st = 0;
      // a whole frame, so the count is independent of where it starts
      repeat (24576) begin
        @(negedge i_clk);
        on += int'(lo_oe[0] === 1'b1);
        ones += int'(lo_oe[0] === 1'b1 && lo[0] === 1'b1);
        st += int'(up[0] !== lo_oe[0]);
      end
      check("lane on", 16'(on), (m == 0) ? 16'h0000 : 16'h3000);
      check("ones", 16'(ones), (m == 0) ? 16'h0000 : 16'h1800);
      check("status", 16'(st), 16'h0000);
      check("status oe", up_oe, 16'hFFFF);
      $display("test drive mode %0d done", m);
    end
    check("eval done", {15'h0000, ev_done}, 16'h0001);
    // eval rises 16 bits after the pulse, which is seen half a bit late
    check("eval count", 16'(ev_cnt), 16'h001F);
    stop_test();
  end
endmodule : tsi_core_test
`default_nettype wire
